// ==== design/pcrc_regs.vh ====
// Register offsets, fields, reset values and timing of the CRC unit
`ifndef PCRC_REGS_VH
`define PCRC_REGS_VH

// ==========================================================
// Register offsets
`define PCRC_OFF_DATA 8'h00
`define PCRC_OFF_SCRATCH 8'h04
`define PCRC_OFF_CTRL 8'h08
`define PCRC_OFF_INIT 8'h10
`define PCRC_OFF_POLY 8'h14

// ==========================================================
// Control register fields
`define PCRC_CTRL_RESET 0
`define PCRC_CTRL_PW_LO 3
`define PCRC_CTRL_PW_HI 4
`define PCRC_CTRL_RI_LO 5
`define PCRC_CTRL_RI_HI 6
`define PCRC_CTRL_RO 7

// ==========================================================
// Encodings
`define PCRC_SIZE_BYTE 2'h0
`define PCRC_SIZE_HALF 2'h1
`define PCRC_SIZE_WORD 2'h2
`define PCRC_REV_NONE 2'h0
`define PCRC_REV_BYTE 2'h1
`define PCRC_REV_HALF 2'h2
`define PCRC_REV_WORD 2'h3
`define PCRC_PW_32 2'h0
`define PCRC_PW_16 2'h1
`define PCRC_PW_8 2'h2
`define PCRC_PW_7 2'h3

// ==========================================================
// Reset values
`define PCRC_RST_DATA 32'hffffffff
`define PCRC_RST_INIT 32'hffffffff
`define PCRC_RST_POLY 32'h04c11db7
`define PCRC_RST_SCRATCH 8'h00
`define PCRC_RST_CTRL 8'h00

// ==========================================================
// Update length in cycles, one byte per cycle
`define PCRC_CYC_WORD 3'h4
`define PCRC_CYC_HALF 3'h2
`define PCRC_CYC_BYTE 3'h1

`endif

// ==== design/pcrc_bit_rev.v ====
// Bit order reversal within bytes, half-words or the whole word
`timescale 1ns/1ps
`include "pcrc_regs.vh"

module pcrc_bit_rev (
    input wire [1:0] mode,
    input wire [31:0] din,
    output wire [31:0] dout
);

    // ==========================================================
    // Per-bit source selection
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            assign dout[i] =
                (mode == `PCRC_REV_BYTE) ? din[(i / 8) * 8 + 7 - i % 8] :
                (mode == `PCRC_REV_HALF) ? din[(i / 16) * 16 + 15 - i % 16] :
                (mode == `PCRC_REV_WORD) ? din[31 - i] :
                din[i];
        end
    endgenerate

endmodule // pcrc_bit_rev

// ==== design/pcrc_byte_step.v ====
// One byte of checksum update, most significant bit first
`timescale 1ns/1ps
`include "pcrc_regs.vh"

module pcrc_byte_step (
    input wire [31:0] crc_in,
    input wire [7:0] data_byte,
    input wire [31:0] poly,
    input wire [1:0] width_sel,
    output reg [31:0] crc_out
);

    reg [31:0] mask;
    reg [31:0] c;
    reg fb;
    integer i;

    // ==========================================================
    // Bitwise division by the programmed polynomial
    always @* begin
        mask = 32'hffffffff;
        c = 32'h00000000;
        fb = 1'b0;
        case (width_sel)
            `PCRC_PW_32: mask = 32'hffffffff;
            `PCRC_PW_16: mask = 32'h0000ffff;
            `PCRC_PW_8: mask = 32'h000000ff;
            `PCRC_PW_7: mask = 32'h0000007f;
            default: mask = 32'hffffffff;
        endcase
        c = crc_in & mask;
        for (i = 0; i < 8; i = i + 1) begin
            case (width_sel)
                `PCRC_PW_32: fb = c[31];
                `PCRC_PW_16: fb = c[15];
                `PCRC_PW_8: fb = c[7];
                `PCRC_PW_7: fb = c[6];
                default: fb = c[31];
            endcase
            fb = fb ^ data_byte[7 - i];
            c = {c[30:0], 1'b0} & mask;
            if (fb) begin
                c = c ^ (poly & mask);
            end
        end
        crc_out = c;
    end

endmodule // pcrc_byte_step

// ==== design/pcrc_unit.v ====
// Programmable CRC unit with register port, input buffer and scratch byte
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "pcrc_regs.vh"

module pcrc_unit (
    input wire mclk,
    input wire srst,
    input wire [7:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire [1:0] bus_size,
    input wire bus_wr,
    input wire bus_rd,
    output reg [31:0] bus_rdata,
    output wire bus_wait,
    output wire crc_busy
);

    // ==========================================================
    // Register state
    reg [31:0] checksum_data_reg_r;
    reg [31:0] init_value_r;
    reg [31:0] poly_coeff_reg_r;
    reg [7:0] scratch_byte_reg_r;
    reg output_reverse_en_r;
    reg [1:0] input_reverse_sel_r;
    reg [1:0] poly_width_sel_r;
    reg reset_req_r;

    // ==========================================================
    // Calculation state
    reg [31:0] cur_data_r;
    reg [2:0] cur_cnt_r;
    reg [31:0] buf_data_r;
    reg [2:0] buf_cnt_r;
    reg buf_valid_r;

    wire [31:0] step_crc;
    wire [31:0] in_rev;
    wire [31:0] out_rev;
    wire busy;
    wire finishing;

    // ==========================================================
    // Address decode
    wire sel_data;
    wire sel_scratch;
    wire sel_ctrl;
    wire sel_init;
    wire sel_poly;
    wire size_word;
    wire size_ok;

    assign sel_data = (bus_addr == `PCRC_OFF_DATA);
    assign sel_scratch = (bus_addr == `PCRC_OFF_SCRATCH);
    assign sel_ctrl = (bus_addr == `PCRC_OFF_CTRL);
    assign sel_init = (bus_addr == `PCRC_OFF_INIT);
    assign sel_poly = (bus_addr == `PCRC_OFF_POLY);
    assign size_word = (bus_size == `PCRC_SIZE_WORD);
    assign size_ok = (bus_size == `PCRC_SIZE_BYTE) |
                     (bus_size == `PCRC_SIZE_HALF) | size_word;

    // ==========================================================
    // Write qualification and wait states
    wire data_wr_ok;
    wire data_wr_wait;
    wire data_rd_wait;
    wire data_take;
    wire ctrl_wr;
    wire init_wr;
    wire poly_wr;
    wire scratch_wr;
    wire rd_take;

    assign data_wr_ok = bus_wr & sel_data & size_ok;
    assign data_wr_wait = data_wr_ok & buf_valid_r;
    assign data_rd_wait = bus_rd & sel_data & (busy | buf_valid_r);
    assign bus_wait = data_wr_wait | data_rd_wait;
    assign data_take = data_wr_ok & ~buf_valid_r;
    assign ctrl_wr = bus_wr & sel_ctrl & size_word;
    assign init_wr = bus_wr & sel_init & size_word;
    assign poly_wr = bus_wr & sel_poly & size_word;
    assign scratch_wr = bus_wr & sel_scratch & size_word;
    assign rd_take = bus_rd & ~data_rd_wait;

    assign busy = (cur_cnt_r != 3'h0);
    assign finishing = busy & (cur_cnt_r == 3'h1);
    assign crc_busy = busy | buf_valid_r;

    // ==========================================================
    // Input shaping: reversal clamped to write width, left aligned
    reg [1:0] eff_rev;
    reg [31:0] in_raw;
    reg [31:0] new_data;
    reg [2:0] new_cnt;

    always @* begin
        eff_rev = input_reverse_sel_r;
        in_raw = bus_wdata;
        case (bus_size)
            `PCRC_SIZE_BYTE: begin
                eff_rev = (input_reverse_sel_r == `PCRC_REV_NONE) ?
                          `PCRC_REV_NONE : `PCRC_REV_BYTE;
                in_raw = {24'h000000, bus_wdata[7:0]};
            end
            `PCRC_SIZE_HALF: begin
                eff_rev = (input_reverse_sel_r == `PCRC_REV_WORD) ?
                          `PCRC_REV_HALF : input_reverse_sel_r;
                in_raw = {16'h0000, bus_wdata[15:0]};
            end
            default: begin
                eff_rev = input_reverse_sel_r;
                in_raw = bus_wdata;
            end
        endcase
    end

    pcrc_bit_rev u_in_rev (
        .mode(eff_rev),
        .din(in_raw),
        .dout(in_rev)
    );

    always @* begin
        new_data = in_rev;
        new_cnt = `PCRC_CYC_WORD;
        case (bus_size)
            `PCRC_SIZE_BYTE: begin
                new_data = {in_rev[7:0], 24'h000000};
                new_cnt = `PCRC_CYC_BYTE;
            end
            `PCRC_SIZE_HALF: begin
                new_data = {in_rev[15:0], 16'h0000};
                new_cnt = `PCRC_CYC_HALF;
            end
            default: begin
                new_data = in_rev;
                new_cnt = `PCRC_CYC_WORD;
            end
        endcase
    end

    // ==========================================================
    // One byte per cycle, high byte first
    pcrc_byte_step u_step (
        .crc_in(checksum_data_reg_r),
        .data_byte(cur_data_r[31:24]),
        .poly(poly_coeff_reg_r),
        .width_sel(poly_width_sel_r),
        .crc_out(step_crc)
    );

    // ==========================================================
    // Configuration registers
    always @(posedge mclk) begin
        if (srst) begin
            init_value_r <= `PCRC_RST_INIT;
            poly_coeff_reg_r <= `PCRC_RST_POLY;
            scratch_byte_reg_r <= `PCRC_RST_SCRATCH;
            output_reverse_en_r <= 1'b0;
            input_reverse_sel_r <= `PCRC_REV_NONE;
            poly_width_sel_r <= `PCRC_PW_32;
            reset_req_r <= 1'b0;
        end else begin
            if (init_wr) begin
                init_value_r <= bus_wdata;
            end
            if (poly_wr) begin
                poly_coeff_reg_r <= bus_wdata;
            end
            if (scratch_wr) begin
                scratch_byte_reg_r <= bus_wdata[7:0];
            end
            if (ctrl_wr) begin
                output_reverse_en_r <= bus_wdata[`PCRC_CTRL_RO];
                input_reverse_sel_r <=
                    bus_wdata[`PCRC_CTRL_RI_HI:`PCRC_CTRL_RI_LO];
                poly_width_sel_r <=
                    bus_wdata[`PCRC_CTRL_PW_HI:`PCRC_CTRL_PW_LO];
            end
            // Set only by software, cleared once the reload is done
            reset_req_r <= ctrl_wr & bus_wdata[`PCRC_CTRL_RESET];
        end
    end

    // ==========================================================
    // Checksum, current word and input buffer
    always @(posedge mclk) begin
        if (srst) begin
            checksum_data_reg_r <= `PCRC_RST_DATA;
            cur_data_r <= 32'h00000000;
            cur_cnt_r <= 3'h0;
            buf_data_r <= 32'h00000000;
            buf_cnt_r <= 3'h0;
            buf_valid_r <= 1'b0;
        end else if (init_wr | reset_req_r) begin
            // Reload drops pending work; a write in the same cycle starts
            if (init_wr) begin
                checksum_data_reg_r <= bus_wdata;
            end else begin
                checksum_data_reg_r <= init_value_r;
            end
            cur_data_r <= data_take ? new_data : 32'h00000000;
            cur_cnt_r <= data_take ? new_cnt : 3'h0;
            buf_valid_r <= 1'b0;
            buf_cnt_r <= 3'h0;
        end else begin
            if (busy) begin
                checksum_data_reg_r <= step_crc;
            end
            if (~busy | finishing) begin
                if (buf_valid_r) begin
                    cur_data_r <= buf_data_r;
                    cur_cnt_r <= buf_cnt_r;
                    buf_valid_r <= 1'b0;
                end else if (data_take) begin
                    cur_data_r <= new_data;
                    cur_cnt_r <= new_cnt;
                end else begin
                    cur_cnt_r <= 3'h0;
                end
            end else begin
                cur_data_r <= {cur_data_r[23:0], 8'h00};
                cur_cnt_r <= cur_cnt_r - 3'h1;
                if (data_take) begin
                    buf_data_r <= new_data;
                    buf_cnt_r <= new_cnt;
                    buf_valid_r <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Read path
    reg [31:0] width_mask;
    wire [31:0] crc_masked;

    always @* begin
        case (poly_width_sel_r)
            `PCRC_PW_32: width_mask = 32'hffffffff;
            `PCRC_PW_16: width_mask = 32'h0000ffff;
            `PCRC_PW_8: width_mask = 32'h000000ff;
            `PCRC_PW_7: width_mask = 32'h0000007f;
            default: width_mask = 32'hffffffff;
        endcase
    end

    assign crc_masked = checksum_data_reg_r & width_mask;

    pcrc_bit_rev u_out_rev (
        .mode(`PCRC_REV_WORD),
        .din(crc_masked),
        .dout(out_rev)
    );

    always @(posedge mclk) begin
        if (srst) begin
            bus_rdata <= 32'h00000000;
        end else if (rd_take & sel_data) begin
            bus_rdata <= output_reverse_en_r ? out_rev : crc_masked;
        end else if (rd_take & size_word) begin
            case (bus_addr)
                `PCRC_OFF_SCRATCH: bus_rdata <= {24'h000000,
                                                 scratch_byte_reg_r};
                `PCRC_OFF_CTRL: bus_rdata <= {24'h000000,
                                              output_reverse_en_r,
                                              input_reverse_sel_r,
                                              poly_width_sel_r,
                                              2'b00, reset_req_r};
                `PCRC_OFF_INIT: bus_rdata <= init_value_r;
                `PCRC_OFF_POLY: bus_rdata <= poly_coeff_reg_r;
                default: bus_rdata <= 32'h00000000;
            endcase
        end else begin
            bus_rdata <= 32'h00000000;
        end
    end

endmodule // pcrc_unit

// ==== sim/pcrc_unit_props.sv ====
// Port-level assertions for the CRC unit
`timescale 1ns/1ps
module pcrc_unit_props (
    input wire mclk,
    input wire srst,
    input wire [7:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire [1:0] bus_size,
    input wire bus_wr,
    input wire bus_rd,
    input wire [31:0] bus_rdata,
    input wire bus_wait,
    input wire crc_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    wire dw = bus_wr && bus_addr == 8'h00 && bus_size != 2'h3;
    wire idle_w = dw && !crc_busy && !bus_wait;
    wire quiet = !bus_wr && !bus_rd;
    // ====================
    // Update length
    a_word_len: assert property (idle_w && bus_size == 2'h2 ##1 quiet[*4]
        |-> crc_busy ##1 !crc_busy) else $error("word update length");
    a_half_len: assert property (idle_w && bus_size == 2'h1 ##1 quiet[*2]
        |-> crc_busy ##1 !crc_busy) else $error("half update length");
    a_byte_len: assert property (idle_w && bus_size == 2'h0 ##1 quiet
        |-> crc_busy ##1 !crc_busy) else $error("byte update length");
    a_stay_idle: assert property (!crc_busy && !bus_wr |=> !crc_busy)
        else $error("busy without a write");
    // ====================
    // Wait states
    a_second_free: assert property (idle_w && bus_size == 2'h2 ##1 dw
        |-> !bus_wait) else $error("second write stalled");
    a_third_wait: assert property (idle_w && bus_size == 2'h2
        ##1 dw && !bus_wait ##1 dw |-> bus_wait)
        else $error("third write not stalled");
    a_read_held: assert property (bus_rd && bus_addr == 8'h00 && crc_busy
        |-> bus_wait) else $error("read taken while busy");
    a_read_free: assert property (bus_rd && !crc_busy |-> !bus_wait)
        else $error("read stalled while idle");
    a_other_free: assert property ((bus_wr || bus_rd) && bus_addr != 8'h00
        |-> !bus_wait) else $error("control access stalled");
    a_rdata_zero: assert property (!(bus_rd && !bus_wait)
        |=> bus_rdata == 32'h0) else $error("read data without read");
endmodule // pcrc_unit_props

bind pcrc_unit pcrc_unit_props u_pcrc_unit_props (.mclk(mclk), .srst(srst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_size(bus_size),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .bus_wait(bus_wait), .crc_busy(crc_busy));

// ==== sim/pcrc_host.sv ====
// Bus host model for the CRC unit register port
`timescale 1ns/1ps
module pcrc_host (
    input wire mclk,
    output reg [7:0] bus_addr,
    output reg [31:0] bus_wdata,
    output reg [1:0] bus_size,
    output reg bus_wr,
    output reg bus_rd,
    input wire [31:0] bus_rdata,
    input wire bus_wait
);
    integer waits;
    initial begin
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_size = 2'h2;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
    // ====================
    // Hold request until an edge takes it
    task hold;
        reg w;
        begin
            waits = 0;
            w = 1'b1;
            while (w && waits < 64) begin
                @(negedge mclk);
                w = bus_wait;
                @(posedge mclk);
                if (w)
                    waits = waits + 1;
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] s);
        begin
            bus_addr <= a;
            bus_wdata <= d;
            bus_size <= s;
            bus_rd <= 1'b0;
            bus_wr <= 1'b1;
            hold;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d);
        begin
            bus_addr <= a;
            bus_size <= 2'h2;
            bus_wr <= 1'b0;
            bus_rd <= 1'b1;
            hold;
            bus_rd <= 1'b0;
            bus_wdata <= ~bus_wdata;
            @(negedge mclk);
            d = bus_rdata;
            @(posedge mclk);
        end
    endtask
    task idle;
        begin
            bus_wr <= 1'b0;
            bus_rd <= 1'b0;
            bus_addr <= ~bus_addr;
            bus_wdata <= ~bus_wdata;
            @(posedge mclk);
        end
    endtask
endmodule // pcrc_host

// ==== sim/testbench.sv ====
// Self-checking testbench for the CRC unit
`timescale 1ns/1ps
module testbench;
    reg mclk;
    reg srst;
    wire [7:0] bus_addr;
    wire [31:0] bus_wdata;
    wire [1:0] bus_size;
    wire bus_wr;
    wire bus_rd;
    wire [31:0] bus_rdata;
    wire bus_wait;
    wire crc_busy;
    integer error_cnt;
    integer compares;
    integer i;
    reg [31:0] crc;
    reg [31:0] poly;
    reg [31:0] init;
    reg [31:0] got;
    reg [31:0] ptab [0:3];
    reg [1:0] pw;
    reg [1:0] ri;
    reg ro;
    pcrc_unit u_pcrc_unit (.mclk(mclk), .srst(srst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_wait(bus_wait),
        .crc_busy(crc_busy));
    pcrc_host u_pcrc_host (.mclk(mclk), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_wait(bus_wait));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ====================
    // Reference model
    function [31:0] rev(input [1:0] m, input [31:0] d);
        integer k;
        for (k = 0; k < 32; k = k + 1)
            rev[k] = m == 2'h0 ? d[k] : m == 2'h1 ? d[(k & 24) + 7 - (k & 7)]
                : m == 2'h2 ? d[(k & 16) + 15 - (k & 15)] : d[31 - k];
    endfunction
    function [31:0] wmask(input [1:0] w);
        wmask = w == 2'h0 ? 32'hffffffff : w == 2'h1 ? 32'h0000ffff
            : w == 2'h2 ? 32'h000000ff : 32'h0000007f;
    endfunction
    function [31:0] step(input [31:0] c, input [7:0] b);
        integer k;
        reg [31:0] m;
        reg fb;
        begin
            m = wmask(pw);
            step = c;
            for (k = 7; k >= 0; k = k - 1) begin
                fb = |(step & (m ^ (m >> 1))) ^ b[k];
                step = (step << 1) & m;
                if (fb)
                    step = step ^ (poly & m);
            end
        end
    endfunction
    function [31:0] dr_exp(input dummy);
        dr_exp = ro ? rev(2'h3, crc & wmask(pw)) : crc & wmask(pw);
    endfunction
    // ====================
    // Shared tasks
    task chk(input [31:0] g, input [31:0] e);
        begin
            compares = compares + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    task rdchk(input [7:0] a, input [31:0] e);
        begin
            u_pcrc_host.rd(a, got);
            if (u_pcrc_host.waits >= 64)
                error_cnt = error_cnt + 1;
            chk(got, e);
        end
    endtask
    task push(input [31:0] d, input [1:0] s);
        reg [31:0] x;
        begin
            x = rev((s == 2'h0 && ri != 2'h0) ? 2'h1
                : (s == 2'h1 && ri == 2'h3) ? 2'h2 : ri, d);
            if (s == 2'h2) begin
                crc = step(crc, x[31:24]);
                crc = step(crc, x[23:16]);
            end
            if (s != 2'h0)
                crc = step(crc, x[15:8]);
            crc = step(crc, x[7:0]);
            u_pcrc_host.wr(8'h00, d, s);
            if (u_pcrc_host.waits >= 64)
                error_cnt = error_cnt + 1;
        end
    endtask
    task cfg(input [1:0] w, input [1:0] r, input o, input rst);
        begin
            pw = w;
            ri = r;
            ro = o;
            if (rst)
                crc = init;
            u_pcrc_host.wr(8'h08, {24'h0, o, r, w, 2'h0, rst}, 2'h2);
            u_pcrc_host.idle;
        end
    endtask
    // ====================
    // Scenarios
    task t_reset;
        begin
            rdchk(8'h00, 32'hffffffff);
            rdchk(8'h14, 32'h04c11db7);
            rdchk(8'h10, 32'hffffffff);
            rdchk(8'h08, 32'h0);
            rdchk(8'h04, 32'h0);
            rdchk(8'h0c, 32'h0);
        end
    endtask
    task t_burst;
        begin
            push(32'h1a2b3c4d, 2'h2);
            push(32'h5a5aa5a5, 2'h2);
            chk(u_pcrc_host.waits, 32'h0);
            push(32'h0f0f1234, 2'h2);
            chk({31'h0, u_pcrc_host.waits != 0}, 32'h1);
            rdchk(8'h00, dr_exp(1'b0));
        end
    endtask
    task t_mixed;
        begin
            cfg(2'h0, 2'h0, 1'b0, 1'b1);
            push(32'h11223344, 2'h2);
            push(32'h00000055, 2'h0);
            push(32'h00006677, 2'h1);
            rdchk(8'h00, dr_exp(1'b0));
        end
    endtask
    task t_rev;
        for (i = 0; i < 4; i = i + 1) begin
            cfg(2'h0, i[1:0], 1'b0, 1'b1);
            push(32'h1a2b3c4d, 2'h2);
            push(32'h000000c3, 2'h0);
            push(32'h0000a55a, 2'h1);
            rdchk(8'h00, dr_exp(1'b0));
        end
    endtask
    task t_width;
        for (i = 0; i < 4; i = i + 1) begin
            u_pcrc_host.wr(8'h14, ptab[i], 2'h2);
            poly = ptab[i];
            cfg(i[1:0], 2'h0, i[0], 1'b1);
            push(32'hdeadbeef, 2'h2);
            push(32'h0000005a, 2'h0);
            rdchk(8'h00, dr_exp(1'b0));
            rdchk(8'h14, ptab[i]);
        end
    endtask
    task t_init;
        begin
            u_pcrc_host.wr(8'h10, 32'h89abcdef, 2'h2);
            init = 32'h89abcdef;
            crc = init;
            rdchk(8'h00, dr_exp(1'b0));
            push(32'h01020304, 2'h2);
            cfg(pw, ri, ro, 1'b1);
            rdchk(8'h00, dr_exp(1'b0));
            rdchk(8'h08, {24'h0, ro, ri, pw, 3'h0});
        end
    endtask
    task t_scratch;
        begin
            u_pcrc_host.wr(8'h04, 32'hffffffa5, 2'h2);
            u_pcrc_host.wr(8'h04, 32'h0000003c, 2'h0);
            cfg(pw, ri, ro, 1'b1);
            rdchk(8'h04, 32'h000000a5);
        end
    endtask
    task summarize;
        begin
            $display("errors %0d compares %0d", error_cnt, compares);
            if (error_cnt == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // ====================
    // Main sequence and watchdog
    initial begin
        error_cnt = 0;
        compares = 0;
        srst = 1'b1;
        crc = 32'hffffffff;
        init = 32'hffffffff;
        poly = 32'h04c11db7;
        pw = 2'h0;
        ri = 2'h0;
        ro = 1'b0;
        ptab[0] = 32'h04c11db7;
        ptab[1] = 32'h00001021;
        ptab[2] = 32'h00000007;
        ptab[3] = 32'h00000009;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_reset;
        t_burst;
        t_mixed;
        t_rev;
        t_width;
        t_init;
        t_scratch;
        summarize;
    end
    initial begin
        #20000;
        error_cnt = error_cnt + 1;
        summarize;
    end
endmodule // testbench
